// *** rtl/eti_regs.svh ***
// register indices, field positions, reset values and cycle counts
`ifndef ETI_REGS_SVH
`define ETI_REGS_SVH
// register indices, byte address is four times the index
`define ETI_IDX_SLEEP_SENSE 6'h35
`define ETI_IDX_EXT_FLAGS 6'h30
`define ETI_IDX_TMR_MASK 6'h31
`define ETI_IDX_TMR_FLAGS 6'h32
`define ETI_IDX_GEN_MASK 6'h33
`define ETI_IDX_CPU_FLAGS 6'h34
`define ETI_IDX_STATUS 6'h36
// field positions
`define ETI_BIT_SE 5
`define ETI_BIT_SM 4
`define ETI_BIT_PIN_FLAG 6
`define ETI_BIT_PIN_EN 6
`define ETI_BIT_OVF_EN 1
`define ETI_BIT_OVF_FLAG 1
`define ETI_BIT_GIE 7
`define ETI_BIT_BUSY 4
`define ETI_BIT_HOLD 3
// writable bits of the sleep and sense control register
`define ETI_MASK_SLEEP_SENSE 8'h33
// reset values
`define ETI_RST_SLEEP_SENSE 8'h00
// vector addresses
`define ETI_VEC_EXT 8'h01
`define ETI_VEC_OVF 8'h02
// cycle counts
`define ETI_ENTRY_CYC 3'h4
`define ETI_JUMP_CYC 3'h2
`define ETI_RETURN_CYC 3'h4
`define ETI_WAKE_CYC 16
`endif

// *** rtl/eti_pkg.sv ***
// types shared by the interrupt and sleep control block
package eti_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} eti_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} eti_apb_rsp_t;
	typedef struct packed {
		logic instr_done;
		logic sleep_op;
		logic ret_op;
	} eti_core_t;
	typedef enum logic [2:0] {
		ST_RUN, ST_ENTRY, ST_JUMP, ST_RETURN, ST_IDLE, ST_PDOWN, ST_WAKE
	} eti_state_t;
	typedef enum logic [1:0] {
		SNS_LOW, SNS_RSVD, SNS_FALL, SNS_RISE
	} eti_sense_t;
endpackage : eti_pkg

// *** rtl/eti_sync2.sv ***
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module eti_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// level in and out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q, meta_d, sync_q, sync_d;

	// first stage is read by the second stage only
	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	// resets to the idle-high pad level, so release shows no false edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : eti_sync2

// *** rtl/eti_ctrl.sv ***
// interrupt flags, vectoring timing and sleep control behind apb
// Summary of operation
// - pin edge sets flag, vector when enabled
// - flag cleared on entry or one-write
// - low-level sensing holds pin flag zero
// - unused register bits read as zero
// - enabled overflow vectors to address two
// - overflow sets flag, entry or write clears
// - pin triggers even when driven as output
// - low pin keeps requesting while enabled
// - four cycles to vector, jump two more
// - service only at instruction boundaries
// - return sequence lasts four cycles
// - one instruction runs after each return
// - sleep only with sleep enable set
// - depth bit picks idle or power-down
// - sense bits: low, reserved, fall, rise
// - pin synchronised before edge detection
// - interrupt wakes sleep, state preserved
// - idle halts cpu, any interrupt wakes
// - power-down wakes on level or watchdog reset only
// - two low samples on watchdog ticks
// - wake delay, vanished level not served
// - entry clears global enable, return sets
`timescale 1ns/100ps
`include "eti_regs.svh"
module eti_ctrl #(
	parameter int WAKE_CYC = `ETI_WAKE_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input eti_pkg::eti_apb_req_t apb_req,
	output eti_pkg::eti_apb_rsp_t apb_rsp,
	// cpu core handshake
	input eti_pkg::eti_core_t core_in,
	output logic vec_take,
	output logic [7:0] vec_addr,
	output logic irq_busy,
	output logic cpu_halt,
	output logic osc_stop,
	// event sources
	input wire logic ext_irq_pin,
	input wire logic tmr_ovf,
	input wire logic wdt_tick,
	input wire logic wdt_reset
);
	import eti_pkg::*;

	logic [7:0] ctl_q, ctl_d;
	logic pin_en_q, pin_en_d;
	logic ovf_en_q, ovf_en_d;
	logic pin_flag_q, pin_flag_d;
	logic ovf_flag_q, ovf_flag_d;
	logic gie_q, gie_d;
	eti_state_t state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic [15:0] wake_q, wake_d;
	logic [1:0] lvl_q, lvl_d;
	logic hold_q, hold_d;
	logic [7:0] vec_q, vec_d;
	logic take_q, take_d;
	logic [7:0] vaddr_q, vaddr_d;
	logic [31:0] prdata_q, prdata_d;
	logic pin_s, pin_prev_q;
	eti_sense_t sense;
	logic rise, fall, edge_hit, level_req, lvl_en;
	logic ext_req, ovf_req, any_req;
	logic take, take_ext, take_ovf, ret_done;
	logic setup, wr, hit;
	logic [5:0] idx;
	logic [7:0] rd_val;
	logic is_entry, is_jump, is_ret, se_bit, sm_bit;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// pad level is seen whatever the pin direction
	eti_sync2 #(
		.W(1)
	) u_pin_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din(ext_irq_pin),
		.dout(pin_s)
	);

	// edges taken from the synchronised level only
	assign sense = eti_sense_t'(ctl_q[1:0]);
	assign rise = pin_s & ~pin_prev_q;
	assign fall = ~pin_s & pin_prev_q;
	assign edge_hit = ((sense == SNS_FALL) & fall) |
		((sense == SNS_RISE) & rise);
	// level request follows the live pin, so a short low may be missed
	assign level_req = (sense == SNS_LOW) & ~pin_s;
	assign lvl_en = (sense == SNS_LOW) & pin_en_q & gie_q;

	// request gating by own enable and global enable
	assign ext_req = (pin_flag_q | level_req) & pin_en_q & gie_q;
	assign ovf_req = ovf_flag_q & ovf_en_q & gie_q;
	assign any_req = ext_req | ovf_req;

	// service only when the running instruction has finished
	assign take = (state_q == ST_RUN) & core_in.instr_done & ~hold_q &
		any_req;
	// lower vector has priority
	assign take_ext = take & ext_req;
	assign take_ovf = take & ~ext_req;
	assign ret_done = (state_q == ST_RETURN) & (cnt_q == 3'h0);

	// apb decode; reads are captured in setup so prdata is registered
	assign setup = apb_req.psel & ~apb_req.penable;
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign idx = apb_req.paddr[7:2];
	always_comb begin
		hit = 1'b1;
		rd_val = 8'h00; // unused bits stay zero
		case (idx)
			`ETI_IDX_SLEEP_SENSE: rd_val = ctl_q;
			`ETI_IDX_EXT_FLAGS: rd_val[`ETI_BIT_PIN_FLAG] = pin_flag_q;
			`ETI_IDX_TMR_MASK: rd_val[`ETI_BIT_OVF_EN] = ovf_en_q;
			`ETI_IDX_TMR_FLAGS: rd_val[`ETI_BIT_OVF_FLAG] = ovf_flag_q;
			`ETI_IDX_GEN_MASK: rd_val[`ETI_BIT_PIN_EN] = pin_en_q;
			`ETI_IDX_CPU_FLAGS: rd_val[`ETI_BIT_GIE] = gie_q;
			`ETI_IDX_STATUS: begin
				rd_val[2:0] = state_q;
				rd_val[`ETI_BIT_HOLD] = hold_q;
				rd_val[`ETI_BIT_BUSY] = irq_busy;
			end
			default: hit = 1'b0;
		endcase
		prdata_d = setup ? {24'h000000, rd_val} : prdata_q;
	end
	assign apb_rsp = '{1'b1, apb_req.psel & apb_req.penable & ~hit, prdata_q};

	// software-written control and mask bits
	always_comb begin
		ctl_d = ctl_q;
		pin_en_d = pin_en_q;
		ovf_en_d = ovf_en_q;
		if (wr && idx == `ETI_IDX_SLEEP_SENSE) begin
			ctl_d = apb_req.pwdata[7:0] & `ETI_MASK_SLEEP_SENSE;
		end
		if (wr && idx == `ETI_IDX_TMR_MASK) begin
			ovf_en_d = apb_req.pwdata[`ETI_BIT_OVF_EN];
		end
		if (wr && idx == `ETI_IDX_GEN_MASK) begin
			pin_en_d = apb_req.pwdata[`ETI_BIT_PIN_EN];
		end
	end

	// flags: hardware set wins over any clear in the same cycle
	always_comb begin
		pin_flag_d = pin_flag_q;
		ovf_flag_d = ovf_flag_q;
		gie_d = gie_q;
		if ((wr && idx == `ETI_IDX_EXT_FLAGS &&
			apb_req.pwdata[`ETI_BIT_PIN_FLAG]) || take_ext) begin
			pin_flag_d = 1'b0;
		end
		if (edge_hit) begin
			pin_flag_d = 1'b1;
		end
		if (sense == SNS_LOW) begin
			pin_flag_d = 1'b0;
		end
		if ((wr && idx == `ETI_IDX_TMR_FLAGS &&
			apb_req.pwdata[`ETI_BIT_OVF_FLAG]) || take_ovf) begin
			ovf_flag_d = 1'b0;
		end
		if (tmr_ovf) begin
			ovf_flag_d = 1'b1;
		end
		if (wr && idx == `ETI_IDX_CPU_FLAGS) begin
			gie_d = apb_req.pwdata[`ETI_BIT_GIE];
		end
		// hardware wins over a software write to the global enable
		if (take) begin
			gie_d = 1'b0;
		end
		if (ret_done) begin
			gie_d = 1'b1;
		end
	end

	// vectoring, return and sleep sequencer
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		hold_d = hold_q;
		vec_d = vec_q;
		take_d = 1'b0;
		vaddr_d = vaddr_q;
		wake_d = wake_q;
		lvl_d = 2'h0;
		unique case (state_q)
			ST_RUN: begin
				if (core_in.instr_done) begin
					hold_d = 1'b0;
				end
				if (take) begin
					state_d = ST_ENTRY;
					cnt_d = `ETI_ENTRY_CYC - 3'h1;
					vec_d = take_ext ? `ETI_VEC_EXT : `ETI_VEC_OVF;
				end else if (core_in.ret_op) begin
					state_d = ST_RETURN;
					cnt_d = `ETI_RETURN_CYC - 3'h1;
				end else if (core_in.sleep_op && se_bit) begin
					state_d = sm_bit ? ST_PDOWN : ST_IDLE;
				end
			end
			ST_ENTRY: begin
				if (cnt_q == 3'h0) begin
					state_d = ST_JUMP;
					cnt_d = `ETI_JUMP_CYC - 3'h1;
					take_d = 1'b1;
					vaddr_d = vec_q;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			ST_JUMP: begin
				if (cnt_q == 3'h0) begin
					state_d = ST_RUN;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			ST_RETURN: begin
				if (cnt_q == 3'h0) begin
					state_d = ST_RUN;
					hold_d = 1'b1;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			ST_IDLE: begin
				// nothing is cleared on wake, the core resumes in place
				if (any_req || wdt_reset) begin
					state_d = ST_RUN;
				end
			end
			ST_PDOWN: begin
				lvl_d = lvl_q;
				// edges and overflow cannot wake from here
				if (wdt_reset) begin
					state_d = ST_RUN;
				end else if (lvl_q == 2'h2 && lvl_en) begin
					state_d = ST_WAKE;
					wake_d = 16'(WAKE_CYC - 1);
					lvl_d = 2'h0;
				end else if (wdt_tick) begin
					// count consecutive low samples, saturating at two
					if (pin_s) begin
						lvl_d = 2'h0;
					end else if (lvl_q != 2'h2) begin
						lvl_d = lvl_q + 2'h1;
					end
				end
			end
			ST_WAKE: begin
				if (wdt_reset) begin
					state_d = ST_RUN;
				end else if (wake_q == 16'h0000) begin
					// level gone: back to sleep, its interrupt is dropped
					state_d = (level_req && lvl_en) ? ST_RUN : ST_PDOWN;
				end else begin
					wake_d = wake_q - 16'h0001;
				end
			end
		endcase
	end

	// all state registers; external reset restarts from run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= `ETI_RST_SLEEP_SENSE;
			pin_en_q <= 1'b0;
			ovf_en_q <= 1'b0;
			pin_flag_q <= 1'b0;
			ovf_flag_q <= 1'b0;
			gie_q <= 1'b0;
			state_q <= ST_RUN;
			cnt_q <= 3'h0;
			wake_q <= 16'h0000;
			lvl_q <= 2'h0;
			hold_q <= 1'b0;
			vec_q <= 8'h00;
			take_q <= 1'b0;
			vaddr_q <= 8'h00;
			prdata_q <= 32'h00000000;
			pin_prev_q <= 1'b1; // matches the synchroniser reset level
		end else begin
			ctl_q <= ctl_d;
			pin_en_q <= pin_en_d;
			ovf_en_q <= ovf_en_d;
			pin_flag_q <= pin_flag_d;
			ovf_flag_q <= ovf_flag_d;
			gie_q <= gie_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			wake_q <= wake_d;
			lvl_q <= lvl_d;
			hold_q <= hold_d;
			vec_q <= vec_d;
			take_q <= take_d;
			vaddr_q <= vaddr_d;
			prdata_q <= prdata_d;
			pin_prev_q <= pin_s;
		end
	end

	// outputs decoded from state registers
	assign se_bit = ctl_q[`ETI_BIT_SE];
	assign sm_bit = ctl_q[`ETI_BIT_SM];
	assign is_entry = (state_q == ST_ENTRY);
	assign is_jump = (state_q == ST_JUMP);
	assign is_ret = (state_q == ST_RETURN);
	assign irq_busy = is_entry | is_jump | is_ret;
	assign cpu_halt = (state_q == ST_IDLE) | (state_q == ST_PDOWN) |
		(state_q == ST_WAKE);
	assign osc_stop = (state_q == ST_PDOWN);
	assign vec_take = take_q;
	assign vec_addr = vaddr_q;

	// checks on the sequencer and flags
	a_level_flag_zero: assert property (
		sense == SNS_LOW |=> !pin_flag_q)
		else $error("pin flag set in low-level mode");
	a_edge_sets_flag: assert property (
		edge_hit |=> pin_flag_q)
		else $error("pin edge did not set flag");
	a_ovf_sets_flag: assert property (
		tmr_ovf |=> ovf_flag_q)
		else $error("overflow did not set flag");
	a_take_clr_ovf: assert property (
		take_ovf && !tmr_ovf |=> !ovf_flag_q)
		else $error("overflow flag kept after entry");
	a_entry_timing: assert property (
		take |=> is_entry [*4] ##1 (is_jump && vec_take))
		else $error("vector not reached after four cycles");
	a_jump_two: assert property (
		$rose(is_jump) |-> is_jump [*2] ##1 state_q == ST_RUN)
		else $error("jump phase not two cycles");
	a_ret_four: assert property (
		$rose(is_ret) |-> is_ret [*4] ##1 (gie_q && hold_q))
		else $error("return not four cycles or enable not set");
	a_gie_off_entry: assert property (
		$rose(is_entry) |-> !gie_q)
		else $error("global enable still set on entry");
	a_hold_blocks: assert property (
		hold_q && state_q == ST_RUN |=> !is_entry)
		else $error("interrupt taken before one instruction");
	a_ovf_vector: assert property (
		take_ovf |=> ##4 vec_addr == `ETI_VEC_OVF)
		else $error("overflow vector address wrong");
	a_sleep_gate: assert property (
		state_q == ST_RUN ##1 cpu_halt |-> $past(se_bit))
		else $error("sleep entered without sleep enable");
	a_sleep_depth: assert property (
		state_q == ST_RUN ##1 cpu_halt |-> osc_stop == $past(sm_bit))
		else $error("sleep depth does not match select bit");
	a_rsvd_quiet: assert property (
		sense == SNS_RSVD |-> !edge_hit && !level_req)
		else $error("reserved sense raised a request");
	a_pdown_wake: assert property (
		osc_stop ##1 state_q == ST_WAKE |-> $past(lvl_q) == 2'h2)
		else $error("power-down woke without two low samples");

	c_ovf_entry: cover property (take_ovf ##5 vec_take);
	c_return: cover property ($fell(is_ret) ##[1:20] core_in.instr_done);
	c_pdown_wake: cover property (state_q == ST_WAKE ##[1:40] !cpu_halt);
	c_idle_wake: cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);
endmodule : eti_ctrl

// *** verif/eti_core_model.sv ***
// core strobe and interrupt pin model for the far side of the block
`timescale 1ns/100ps
module eti_core_model (
	// clock
	input wire logic pclk,
	// core strobes and pad
	output eti_pkg::eti_core_t core_out,
	output logic pin
);
	import eti_pkg::*;

	// idle core, pad at rest high
	initial begin
		core_out = '0;
		pin = 1'b1;
	end

	// one-cycle strobe: 4 instruction end, 2 sleep, 1 return
	task automatic strobe(input logic [2:0] sel);
		@(posedge pclk);
		core_out <= sel;
		@(posedge pclk);
		core_out <= '0;
	endtask : strobe

	// pad level stays until changed, so a low source outlasts the
	// instruction in flight
	task automatic drive_pin(input logic v);
		@(posedge pclk);
		pin <= v;
	endtask : drive_pin
endmodule : eti_core_model

// *** verif/ext_timer_irq_sleep_ctrl_test.sv ***
// self-checking bench for the interrupt and sleep control block
`timescale 1ns/100ps
`include "eti_regs.svh"
module ext_timer_irq_sleep_ctrl_test;
	import eti_pkg::*;
	// short wake delay keeps the power-down cases quick
	localparam int WAKE = 8;
	localparam logic [2:0] OP_INSTR = 3'h4;
	localparam logic [2:0] OP_SLEEP = 3'h2;
	localparam logic [2:0] OP_RET = 3'h1;
	logic pclk;
	logic presetn;
	eti_apb_req_t apb_req;
	eti_apb_rsp_t apb_rsp;
	eti_core_t core_in;
	logic vec_take;
	logic [7:0] vec_addr;
	logic irq_busy;
	logic cpu_halt;
	logic osc_stop;
	logic ext_irq_pin;
	logic tmr_ovf;
	logic wdt_tick;
	logic wdt_reset;
	int fail_count;
	int total_checks;
	int n;
	logic [31:0] rd;
	logic err;

	// 200 mhz clock
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	eti_ctrl #(.WAKE_CYC(WAKE)) i_dut (
		.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp),
		.core_in(core_in), .vec_take(vec_take), .vec_addr(vec_addr),
		.irq_busy(irq_busy), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
		.ext_irq_pin(ext_irq_pin), .tmr_ovf(tmr_ovf),
		.wdt_tick(wdt_tick), .wdt_reset(wdt_reset)
	);

	eti_core_model i_core (
		.pclk(pclk), .core_out(core_in), .pin(ext_irq_pin)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one apb transfer; data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [5:0] idx,
			input logic [31:0] wd);
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= {idx, 2'b00};
		apb_req.pwdata <= wd;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	task automatic reg_rd(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check($sformatf("reg %h", idx), rd, exp);
	endtask : reg_rd

	// single-cycle pulse: 0 overflow, 1 watchdog tick, else watchdog reset
	task automatic pulse(input int which);
		@(posedge pclk);
		case (which)
			0: tmr_ovf <= 1'b1;
			1: wdt_tick <= 1'b1;
			default: wdt_reset <= 1'b1;
		endcase
		@(posedge pclk);
		tmr_ovf <= 1'b0;
		wdt_tick <= 1'b0;
		wdt_reset <= 1'b0;
	endtask : pulse

	// counts edges while the sequencer is busy
	task automatic wait_busy();
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (irq_busy === 1'b1 && n < 20);
	endtask : wait_busy

	// instruction boundary, then vector five cycles after the take
	task automatic take(input logic [7:0] addr);
		i_core.strobe(OP_INSTR);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (vec_take !== 1'b1 && n < 20);
		check("vector delay", n, 5);
		check("vector address", vec_addr, addr);
		wait_busy();
	endtask : take

	// return sequence; optionally one instruction to clear the hold
	task automatic ret_seq(input logic clr);
		i_core.strobe(OP_RET);
		wait_busy();
		check("return cycles", n, 5);
		if (clr) begin
			i_core.strobe(OP_INSTR);
		end
	endtask : ret_seq

	// a hang ends the run as a mismatch
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		fail_count = 0;
		total_checks = 0;
		presetn = 1'b0;
		apb_req = '0;
		tmr_ovf = 1'b0;
		wdt_tick = 1'b0;
		wdt_reset = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unused bits and an unmapped word
		reg_rd(`ETI_IDX_SLEEP_SENSE, 32'h0);
		reg_rd(`ETI_IDX_TMR_MASK, 32'h0);
		reg_rd(6'h00, 32'h0);
		check("slverr", err, 1'b1);
		apb(1'b1, `ETI_IDX_SLEEP_SENSE, 32'hffffffff);
		reg_rd(`ETI_IDX_SLEEP_SENSE, 32'h33);
		apb(1'b1, `ETI_IDX_TMR_MASK, 32'hffffffff);
		reg_rd(`ETI_IDX_TMR_MASK, 32'h02);
		apb(1'b1, `ETI_IDX_GEN_MASK, 32'hffffffff);
		reg_rd(`ETI_IDX_EXT_FLAGS, 32'h0);
		// every sense code with a three-cycle low pulse, global enable off
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, `ETI_IDX_SLEEP_SENSE, m);
			i_core.drive_pin(1'b0);
			repeat (2) @(posedge pclk);
			i_core.drive_pin(1'b1);
			repeat (6) @(posedge pclk);
			reg_rd(`ETI_IDX_EXT_FLAGS, m[1] ? 32'h40 : 32'h0);
			apb(1'b1, `ETI_IDX_EXT_FLAGS, 32'h40);
			reg_rd(`ETI_IDX_EXT_FLAGS, 32'h0);
		end
		// overflow held off until an instruction boundary
		apb(1'b1, `ETI_IDX_CPU_FLAGS, 32'h80);
		pulse(0);
		repeat (4) @(posedge pclk);
		check("busy without boundary", irq_busy, 1'b0);
		reg_rd(`ETI_IDX_TMR_FLAGS, 32'h02);
		take(8'h02);
		reg_rd(`ETI_IDX_TMR_FLAGS, 32'h0);
		reg_rd(`ETI_IDX_CPU_FLAGS, 32'h0);
		ret_seq(1'b0);
		reg_rd(`ETI_IDX_CPU_FLAGS, 32'h80);
		// pending overflow waits one instruction after the return
		pulse(0);
		i_core.strobe(OP_INSTR);
		repeat (3) @(posedge pclk);
		check("take after return", irq_busy, 1'b0);
		take(8'h02);
		ret_seq(1'b1);
		// write-one clear with global enable off
		apb(1'b1, `ETI_IDX_CPU_FLAGS, 32'h0);
		pulse(0);
		apb(1'b1, `ETI_IDX_TMR_FLAGS, 32'h02);
		reg_rd(`ETI_IDX_TMR_FLAGS, 32'h0);
		apb(1'b1, `ETI_IDX_CPU_FLAGS, 32'h80);
		// falling edge taken, flag cleared on entry
		apb(1'b1, `ETI_IDX_SLEEP_SENSE, 32'h02);
		i_core.drive_pin(1'b0);
		repeat (6) @(posedge pclk);
		take(8'h01);
		reg_rd(`ETI_IDX_EXT_FLAGS, 32'h0);
		i_core.drive_pin(1'b1);
		ret_seq(1'b1);
		// low level keeps requesting
		apb(1'b1, `ETI_IDX_SLEEP_SENSE, 32'h00);
		i_core.drive_pin(1'b0);
		repeat (4) @(posedge pclk);
		take(8'h01);
		ret_seq(1'b1);
		take(8'h01);
		i_core.drive_pin(1'b1);
		ret_seq(1'b1);
		// sleep needs the enable bit, set just before the strobe
		i_core.strobe(OP_SLEEP);
		@(posedge pclk);
		check("halt without enable", cpu_halt, 1'b0);
		apb(1'b1, `ETI_IDX_SLEEP_SENSE, 32'h20);
		i_core.strobe(OP_SLEEP);
		@(posedge pclk);
		check("idle halt", cpu_halt, 1'b1);
		check("idle osc", osc_stop, 1'b0);
		reg_rd(`ETI_IDX_STATUS, 32'h04);
		pulse(0);
		repeat (2) @(posedge pclk);
		check("idle wake", cpu_halt, 1'b0);
		take(8'h02);
		ret_seq(1'b1);
		// power-down ignores overflow; level must last to the wake end
		apb(1'b1, `ETI_IDX_SLEEP_SENSE, 32'h30);
		i_core.strobe(OP_SLEEP);
		@(posedge pclk);
		check("pdown osc", osc_stop, 1'b1);
		pulse(0);
		repeat (3) @(posedge pclk);
		check("pdown overflow", cpu_halt, 1'b1);
		i_core.drive_pin(1'b0);
		repeat (4) @(posedge pclk);
		pulse(1);
		pulse(1);
		i_core.drive_pin(1'b1);
		repeat (WAKE + 4) @(posedge pclk);
		check("vanished wake", osc_stop, 1'b1);
		pulse(1);
		i_core.drive_pin(1'b0);
		repeat (4) @(posedge pclk);
		pulse(1);
		repeat (WAKE + 4) @(posedge pclk);
		check("one sample", cpu_halt, 1'b1);
		pulse(1);
		repeat (WAKE + 4) @(posedge pclk);
		check("two samples", cpu_halt, 1'b0);
		take(8'h01);
		i_core.drive_pin(1'b1);
		ret_seq(1'b1);
		// watchdog reset leaves power-down
		i_core.strobe(OP_SLEEP);
		pulse(2);
		@(posedge pclk);
		check("watchdog wake", cpu_halt, 1'b0);
		// reset while in power-down restarts with cleared registers
		i_core.strobe(OP_SLEEP);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("reset halt", cpu_halt, 1'b0);
		check("reset osc", osc_stop, 1'b0);
		presetn <= 1'b1;
		reg_rd(`ETI_IDX_SLEEP_SENSE, 32'h0);
		reg_rd(`ETI_IDX_CPU_FLAGS, 32'h0);
		report_and_stop();
	end
endmodule : ext_timer_irq_sleep_ctrl_test
